// file: hw/adrs_pkg.sv
package adrs_pkg;
  // channel count and sample width of the converter core
  localparam int ADRS_NCH = 8;
  localparam int ADRS_DW = 10;
  localparam int ADRS_CW = 3;
  localparam int ADRS_AW = 8;

  // register byte offsets on the bus
  localparam logic [7:0] ADRS_OFF_CTRL = 8'h00;
  localparam logic [7:0] ADRS_OFF_MODE = 8'h04;
  localparam logic [7:0] ADRS_OFF_CHEN = 8'h10;
  localparam logic [7:0] ADRS_OFF_STAT = 8'h1c;
  localparam logic [7:0] ADRS_OFF_LAST = 8'h20;
  localparam logic [7:0] ADRS_OFF_IRQ_STAT = 8'h24;
  localparam logic [7:0] ADRS_OFF_IRQ_MASK = 8'h28;
  localparam logic [7:0] ADRS_OFF_CHDATA = 8'h30;
  localparam logic [7:0] ADRS_OFF_CHDATA_END = 8'h4c;

  // field positions
  localparam int ADRS_CTRL_START = 0;
  localparam int ADRS_MODE_SLEEP = 0;
  localparam int ADRS_STAT_DONE_LSB = 0;
  localparam int ADRS_STAT_OVR_LSB = 8;
  localparam int ADRS_STAT_RDY = 16;
  localparam int ADRS_STAT_GOV = 17;
  localparam int ADRS_STAT_BUSY = 18;
  localparam int ADRS_STAT_SLEEP = 19;
  localparam int ADRS_LAST_CH_LSB = 12;

  // interrupt event bits
  localparam int ADRS_IRQ_W = 4;
  localparam int ADRS_IRQ_RDY = 0;
  localparam int ADRS_IRQ_GOV = 1;
  localparam int ADRS_IRQ_OVR = 2;
  localparam int ADRS_IRQ_SEQ = 3;

  // reset values
  localparam logic [ADRS_NCH-1:0] ADRS_CHEN_RST = 8'h00;
  localparam logic [ADRS_IRQ_W-1:0] ADRS_IRQ_RST = 4'h0;
  localparam logic [ADRS_DW-1:0] ADRS_DATA_RST = 10'h000;
  localparam logic [ADRS_CW-1:0] ADRS_CH_RST = 3'h0;
  localparam logic [ADRS_CW-1:0] ADRS_CH_LAST = 3'h7;
  localparam logic [31:0] ADRS_RD_ZERO = 32'h0000_0000;

  // sequencer states
  typedef enum logic [2:0] {
    ADRS_ST_IDLE = 3'b001,
    ADRS_ST_ISSUE = 3'b010,
    ADRS_ST_WAIT = 3'b100
  } adrs_state_t;
endpackage

// file: hw/adrs_chan.sv
// per-channel result holder with conversion-done and overrun flags
module adrs_chan
  import adrs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic store_i,
  input wire logic [ADRS_DW-1:0] data_i,
  input wire logic clr_done_i,
  input wire logic clr_ovr_i,
  output logic [ADRS_DW-1:0] data_o,
  output logic done_o,
  output logic ovr_o
);
  // result is kept only when the sequencer says it is really stored
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      data_o <= ADRS_DATA_RST;
    end else if (store_i) begin
      data_o <= data_i;
    end
  end

  // set beats clear so a conversion landing on a read is never lost
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      done_o <= 1'b0;
    end else begin
      done_o <= store_i | (done_o & ~clr_done_i);
    end
  end

  // overrun: a new result while the old one is still unread
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      ovr_o <= 1'b0;
    end else begin
      ovr_o <= (store_i & done_o & ~clr_done_i)
        | (ovr_o & ~clr_ovr_i);
    end
  end
endmodule

// file: hw/adrs_seq.sv
// walks the enabled channels, one conversion at a time, and handles sleep
module adrs_seq
  import adrs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic [ADRS_NCH-1:0] chan_en_i,
  input wire logic sleep_en_i,
  input wire logic eoc_i,
  output logic conv_start_o,
  output logic [ADRS_CW-1:0] conv_chan_o,
  output logic sleep_o,
  output logic busy_o,
  output logic seq_done_o,
  output logic conv_end_o
);
  adrs_state_t state;
  logic last_ch;

  assign last_ch = (conv_chan_o == ADRS_CH_LAST);
  // an end of conversion only counts while a conversion is pending
  assign conv_end_o = eoc_i & (state == ADRS_ST_WAIT);

  // scan one channel per cycle; disabled ones are skipped
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      state <= ADRS_ST_IDLE;
      conv_chan_o <= ADRS_CH_RST;
      conv_start_o <= 1'b0;
      seq_done_o <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      seq_done_o <= 1'b0;
      case (state)
        ADRS_ST_IDLE: begin
          if (start_i) begin
            conv_chan_o <= ADRS_CH_RST;
            state <= ADRS_ST_ISSUE;
          end
        end
        ADRS_ST_ISSUE: begin
          if (chan_en_i[conv_chan_o]) begin
            conv_start_o <= 1'b1;
            state <= ADRS_ST_WAIT;
          end else if (last_ch) begin
            seq_done_o <= 1'b1;
            state <= ADRS_ST_IDLE;
          end else begin
            conv_chan_o <= conv_chan_o + 3'h1;
          end
        end
        ADRS_ST_WAIT: begin
          if (eoc_i && last_ch) begin
            seq_done_o <= 1'b1;
            state <= ADRS_ST_IDLE;
          end else if (eoc_i) begin
            conv_chan_o <= conv_chan_o + 3'h1;
            state <= ADRS_ST_ISSUE;
          end
        end
        default: begin
          state <= ADRS_ST_IDLE;
        end
      endcase
    end
  end

  assign busy_o = (state != ADRS_ST_IDLE);

  // sleep is only entered once a conversion ends, never straight from idle
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      sleep_o <= 1'b0;
    end else if (!sleep_en_i) begin
      sleep_o <= 1'b0;
    end else if (conv_end_o) begin
      sleep_o <= 1'b1;
    end else if (start_i && state == ADRS_ST_IDLE) begin
      sleep_o <= 1'b0;
    end
  end
endmodule

// file: hw/adrs_top.sv
// What this block does
// - only a last-result read clears result-ready; channel reads leave it
// - channel or last-result read clears that channel's done flag
// - finished enabled conversion stores to channel and last result, sets ready
// - channel disabled before the cycle its conversion ends gets no done flag
// - conversion ending with done still set raises channel overrun
// - conversion ending with ready still set raises global overrun
// - status read resets channel overrun flags unless a new one arises
// - status read resets global overrun unless a new one arises
// - channel read clears only its own done flag
// - result-ready rises only when a result is really stored
// - sleep written while idle takes effect at next conversion end
module adrs_top
  import adrs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [ADRS_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic eoc_i,
  input wire logic [ADRS_DW-1:0] eoc_data_i,
  output logic conv_start_o,
  output logic [ADRS_CW-1:0] conv_chan_o,
  output logic sleep_o,
  output logic irq_o
);
  // software-visible state
  logic [ADRS_NCH-1:0] chan_en;
  logic sleep_en;
  logic [ADRS_DW-1:0] latest_result_reg;
  logic [ADRS_CW-1:0] last_chan;
  logic result_ready_flag;
  logic global_overrun_flag;
  logic [ADRS_IRQ_W-1:0] irq_stat;
  logic [ADRS_IRQ_W-1:0] irq_mask;

  // per-channel state
  logic [ADRS_DW-1:0] ch_data [ADRS_NCH];
  logic [ADRS_NCH-1:0] ch_done;
  logic [ADRS_NCH-1:0] channel_overrun_flag;
  logic [ADRS_NCH-1:0] ch_store;
  logic [ADRS_NCH-1:0] ch_clr_done;

  // bus decode
  logic acc;
  logic rd_acc;
  logic wr_acc;
  logic wr_lane0;
  logic rd_stat;
  logic rd_last;
  logic rd_chdata;
  logic [ADRS_CW-1:0] rd_chan;
  logic [31:0] rd_mux;
  logic start_cmd;
  logic wr_mode;
  logic wr_chen;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic [ADRS_IRQ_W-1:0] next_irq_stat;

  // sequencer links
  logic busy;
  logic seq_done;
  logic conv_end;
  logic store;
  logic new_gov;
  logic [ADRS_IRQ_W-1:0] irq_evt;

  // the request is taken on the first cycle it is seen while waitrequest
  // is high; the answer follows exactly one cycle later
  assign acc = (avs_read_i | avs_write_i) & avs_waitrequest_o;
  assign rd_acc = acc & avs_read_i;
  assign wr_acc = acc & avs_write_i;
  assign wr_lane0 = wr_acc & avs_byteenable_i[0];

  // read side effects are keyed to the decoded register
  assign rd_stat = rd_acc & (avs_address_i == ADRS_OFF_STAT);
  assign rd_last = rd_acc & (avs_address_i == ADRS_OFF_LAST);
  assign rd_chdata = rd_acc & (avs_address_i >= ADRS_OFF_CHDATA)
    & (avs_address_i <= ADRS_OFF_CHDATA_END)
    & (avs_address_i[1:0] == 2'h0);
  assign rd_chan = ADRS_CW'((avs_address_i - ADRS_OFF_CHDATA) >> 2);

  // start is a strobe; a start while busy is simply ignored by the sequencer
  assign start_cmd = wr_lane0 & (avs_address_i == ADRS_OFF_CTRL)
    & avs_writedata_i[ADRS_CTRL_START];

  // write strobes per register; every write needs byte lane 0, since
  // all writable fields sit in bits 7:0 and other lanes are ignored
  assign wr_mode = wr_lane0 & (avs_address_i == ADRS_OFF_MODE);
  assign wr_chen = wr_lane0 & (avs_address_i == ADRS_OFF_CHEN);
  assign wr_irq_stat = wr_lane0 & (avs_address_i == ADRS_OFF_IRQ_STAT);
  assign wr_irq_mask = wr_lane0 & (avs_address_i == ADRS_OFF_IRQ_MASK);

  // waitrequest stays high between requests; low for one answer cycle
  // so back-to-back requests are taken every other cycle at most
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= ~acc;
    end
  end

  // read data snapshot taken with the side effects, so both agree
  // an event landing on the taking edge shows in the next read instead
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      avs_readdata_o <= ADRS_RD_ZERO;
    end else if (rd_acc) begin
      avs_readdata_o <= rd_mux;
    end
  end

  // read multiplexer; unmapped offsets read as zero
  // channel data words share one decode: address range and word alignment
  always_comb begin
    rd_mux = ADRS_RD_ZERO;
    case (avs_address_i)
      ADRS_OFF_MODE: begin
        rd_mux[ADRS_MODE_SLEEP] = sleep_en;
      end
      ADRS_OFF_CHEN: begin
        rd_mux[ADRS_NCH-1:0] = chan_en;
      end
      ADRS_OFF_STAT: begin
        rd_mux[ADRS_STAT_DONE_LSB +: ADRS_NCH] = ch_done;
        rd_mux[ADRS_STAT_OVR_LSB +: ADRS_NCH] = channel_overrun_flag;
        rd_mux[ADRS_STAT_RDY] = result_ready_flag;
        rd_mux[ADRS_STAT_GOV] = global_overrun_flag;
        rd_mux[ADRS_STAT_BUSY] = busy;
        rd_mux[ADRS_STAT_SLEEP] = sleep_o;
      end
      ADRS_OFF_LAST: begin
        rd_mux[ADRS_DW-1:0] = latest_result_reg;
        rd_mux[ADRS_LAST_CH_LSB +: ADRS_CW] = last_chan;
      end
      ADRS_OFF_IRQ_STAT: begin
        rd_mux[ADRS_IRQ_W-1:0] = irq_stat;
      end
      ADRS_OFF_IRQ_MASK: begin
        rd_mux[ADRS_IRQ_W-1:0] = irq_mask;
      end
      default: begin
        if (rd_chdata) begin
          rd_mux[ADRS_DW-1:0] = ch_data[rd_chan];
        end
      end
    endcase
  end

  // channel enable mask
  // a channel disabled before the cycle its conversion ends loses that result altogether
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      chan_en <= ADRS_CHEN_RST;
    end else if (wr_chen) begin
      chan_en <= avs_writedata_i[ADRS_NCH-1:0];
    end
  end

  // sleep setting; it only arms the sequencer, which picks the moment
  // written while idle, it waits for the end of the next conversion
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      sleep_en <= 1'b0;
    end else if (wr_mode) begin
      sleep_en <= avs_writedata_i[ADRS_MODE_SLEEP];
    end
  end

  adrs_seq u_seq (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .start_i(start_cmd),
    .chan_en_i(chan_en),
    .sleep_en_i(sleep_en),
    .eoc_i(eoc_i),
    .conv_start_o(conv_start_o),
    .conv_chan_o(conv_chan_o),
    .sleep_o(sleep_o),
    .busy_o(busy),
    .seq_done_o(seq_done),
    .conv_end_o(conv_end)
  );

  // a result is stored only if its own channel is still enabled; other
  // channels' enables play no part, so a disable elsewhere cannot mask it
  // a disable written in the same cycle as the conversion end is too late
  assign store = conv_end & chan_en[conv_chan_o];

  // a new global overrun: stored result on top of an unread one
  // a last-result read in the same cycle consumes the old one: no overrun
  assign new_gov = store & result_ready_flag & ~rd_last;

  // per-channel store and done-clear strobes
  genvar gi;
  generate
    for (gi = 0; gi < ADRS_NCH; gi++) begin : g_ch
      assign ch_store[gi] = store & (conv_chan_o == ADRS_CW'(gi));
      // only the addressed channel, or the one named by last result
      assign ch_clr_done[gi] =
        (rd_chdata & (rd_chan == ADRS_CW'(gi)))
        | (rd_last & (last_chan == ADRS_CW'(gi)));

      adrs_chan u_chan (
        .core_clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .store_i(ch_store[gi]),
        .data_i(eoc_data_i),
        .clr_done_i(ch_clr_done[gi]),
        .clr_ovr_i(rd_stat),
        .data_o(ch_data[gi]),
        .done_o(ch_done[gi]),
        .ovr_o(channel_overrun_flag[gi])
      );
    end
  endgenerate

  // shared last result, tagged with its channel
  // the tag tells a last-result read which done flag to clear
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      latest_result_reg <= ADRS_DATA_RST;
      last_chan <= ADRS_CH_RST;
    end else if (store) begin
      latest_result_reg <= eoc_data_i;
      last_chan <= conv_chan_o;
    end
  end

  // result ready: set by a real store, cleared only by a last-result read
  // a channel data read never touches it, even in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      result_ready_flag <= 1'b0;
    end else begin
      result_ready_flag <= store
        | (result_ready_flag & ~rd_last);
    end
  end

  // global overrun; a fresh overrun wins over the status-read reset
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      global_overrun_flag <= 1'b0;
    end else begin
      global_overrun_flag <= new_gov
        | (global_overrun_flag & ~rd_stat);
    end
  end

  // interrupt events
  assign irq_evt[ADRS_IRQ_RDY] = store;
  assign irq_evt[ADRS_IRQ_GOV] = new_gov;
  assign irq_evt[ADRS_IRQ_OVR] = |(ch_store & ch_done & ~ch_clr_done);
  assign irq_evt[ADRS_IRQ_SEQ] = seq_done;

  // sticky event bits, write one to clear; events are or-ed in after the
  // clear, so an event in the clear cycle survives and is never missed
  always_comb begin
    next_irq_stat = irq_stat;
    if (wr_irq_stat) begin
      next_irq_stat = irq_stat & ~avs_writedata_i[ADRS_IRQ_W-1:0];
    end
    next_irq_stat = next_irq_stat | irq_evt;
  end

  // event bits register
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      irq_stat <= ADRS_IRQ_RST;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  // interrupt mask, same layout as the event bits
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      irq_mask <= ADRS_IRQ_RST;
    end else if (wr_irq_mask) begin
      irq_mask <= avs_writedata_i[ADRS_IRQ_W-1:0];
    end
  end

  // level interrupt, registered; lags the status bit by one cycle
  // the output then comes straight from a flop, at one cycle of latency
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask);
    end
  end
endmodule

// file: test/adrs_top_chk.sv
// watches the register bus and converter link of adrs_top
module adrs_top_chk
  import adrs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic [ADRS_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic eoc_i,
  input wire logic conv_start_o,
  input wire logic [ADRS_CW-1:0] conv_chan_o,
  input wire logic sleep_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic take, is_stat, is_last, stored;
  logic [ADRS_NCH-1:0] en_m;
  logic odd, q_ovr, q_rdy, rdy_on, a_ovr, a_rdy, a_on;
  // a request is taken only while waitrequest still stands high
  assign take = (avs_read_i | avs_write_i) & avs_waitrequest_o;
  assign is_stat = take & avs_read_i & (avs_address_i == ADRS_OFF_STAT);
  assign is_last = take & avs_read_i & (avs_address_i == ADRS_OFF_LAST);
  assign stored = eoc_i & en_m[conv_chan_o];
  // quiet windows: no conversion end since the last clearing read
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      en_m <= '0;
      {odd, q_ovr, q_rdy, rdy_on, a_ovr, a_rdy, a_on} <= 7'h00;
    end else begin
      if (take & avs_write_i & avs_byteenable_i[0]
          & (avs_address_i == ADRS_OFF_CHEN))
        en_m <= avs_writedata_i[ADRS_NCH-1:0];
      if (eoc_i)
        q_ovr <= 1'b0;
      else if (is_stat)
        q_ovr <= 1'b1;
      if (eoc_i)
        q_rdy <= 1'b0;
      else if (is_last)
        q_rdy <= 1'b1;
      if (stored)
        rdy_on <= 1'b1;
      else if (is_last)
        rdy_on <= 1'b0;
      if (take) begin
        odd <= avs_read_i & (avs_address_i == 8'h08);
        a_ovr <= is_stat & q_ovr & !eoc_i;
        a_rdy <= is_stat & q_rdy & !eoc_i;
        a_on <= is_stat & rdy_on;
      end
    end
  end
  wait_answer_a: assert property (take |=> !avs_waitrequest_o)
    else $error("no answer one cycle after a request");
  wait_single_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer held longer than one cycle");
  start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
    else $error("conversion start longer than one cycle");
  chan_hold_a: assert property (conv_start_o |=> $stable(conv_chan_o))
    else $error("converting channel moved after start");
  sleep_cause_a: assert property ($rose(sleep_o) |-> $past(eoc_i))
    else $error("sleep entered away from a conversion end");
  unmapped_zero_a: assert property (!avs_waitrequest_o && odd
    |-> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  ovr_cleared_a: assert property (!avs_waitrequest_o && a_ovr
    |-> avs_readdata_o[ADRS_STAT_OVR_LSB +: ADRS_NCH] == 8'h00)
    else $error("channel overrun survived a status read");
  gov_cleared_a: assert property (!avs_waitrequest_o && a_ovr
    |-> !avs_readdata_o[ADRS_STAT_GOV])
    else $error("global overrun survived a status read");
  ready_cleared_a: assert property (!avs_waitrequest_o && a_rdy
    |-> !avs_readdata_o[ADRS_STAT_RDY])
    else $error("result ready survived a last result read");
  ready_set_a: assert property (!avs_waitrequest_o && a_on
    |-> avs_readdata_o[ADRS_STAT_RDY])
    else $error("result ready missing after a stored result");
  cover property ($rose(sleep_o));
  cover property (!avs_waitrequest_o && a_ovr);
  cover property (eoc_i && take);
endmodule

bind adrs_top adrs_top_chk u_chk (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .eoc_i(eoc_i),
  .conv_start_o(conv_start_o), .conv_chan_o(conv_chan_o), .sleep_o(sleep_o));

// file: test/adrs_result_status_flags_bench.sv
module adrs_result_status_flags_bench
  import adrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, rd, wr, eoc, wreq, cs, sl, irq, rdy, gov, slp;
  logic [7:0] adr, en, done, ovr;
  logic [31:0] wdat, rdat;
  logic [3:0] be, ist, imsk;
  logic [9:0] edat, ldat;
  logic [9:0] cdat [8];
  logic [2:0] cch, lch, ch;
  int errors, total_checks, seed;
  logic [7:0] ra [10] = '{ADRS_OFF_CTRL, ADRS_OFF_MODE, 8'h08, ADRS_OFF_CHEN,
    ADRS_OFF_STAT, ADRS_OFF_LAST, ADRS_OFF_IRQ_STAT, ADRS_OFF_IRQ_MASK,
    ADRS_OFF_CHDATA, ADRS_OFF_CHDATA_END};

  adrs_top u_dut (.core_clk_i(clk), .rstn_i(rst_n), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .eoc_i(eoc), .eoc_data_i(edat), .conv_start_o(cs), .conv_chan_o(cch),
    .sleep_o(sl), .irq_o(irq));

  // 200 mhz core clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task results;
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // what a read should return, from the reference flags
  function automatic logic [31:0] expv(input logic [7:0] a);
    case (a)
      ADRS_OFF_MODE: expv = {31'h0, slp};
      ADRS_OFF_CHEN: expv = {24'h0, en};
      ADRS_OFF_STAT: expv = {14'h0, gov, rdy, ovr, done};
      ADRS_OFF_LAST: expv = {17'h0, lch, 2'h0, ldat};
      ADRS_OFF_IRQ_STAT: expv = {28'h0, ist};
      ADRS_OFF_IRQ_MASK: expv = {28'h0, imsk};
      default: expv = (a >= ADRS_OFF_CHDATA && a <= ADRS_OFF_CHDATA_END) ?
        {22'h0, cdat[3'((a - ADRS_OFF_CHDATA) >> 2)]} : 32'h0;
    endcase
  endfunction

  // one bus word; ev puts a conversion end on the taking edge
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic ev);
    logic [31:0] e, m;
    logic [9:0] v;
    logic [7:0] eo;
    logic [2:0] k;
    v = 10'($random(seed));
    e = expv(a);
    m = (a == ADRS_OFF_STAT) ? 32'hfff3_ffff :
        (a == ADRS_OFF_IRQ_STAT) ? 32'h0000_0007 : 32'hffff_ffff;
    k = 3'((a - ADRS_OFF_CHDATA) >> 2);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    eoc <= ev;
    edat <= v;
    @(posedge clk);
    eoc <= 1'b0;
    // clears land first so that a same-edge set survives them
    eo = en;
    if (!w && a == ADRS_OFF_STAT) {ovr, gov} = 9'h000;
    if (!w && a == ADRS_OFF_LAST) {rdy, done[lch]} = 2'b00;
    if (!w && a >= ADRS_OFF_CHDATA && a <= ADRS_OFF_CHDATA_END) done[k] = 0;
    if (w && a == ADRS_OFF_CHEN) en = d[7:0];
    if (w && a == ADRS_OFF_MODE) slp = d[0];
    if (w && a == ADRS_OFF_IRQ_STAT) ist = ist & ~d[3:0];
    if (w && a == ADRS_OFF_IRQ_MASK) imsk = d[3:0];
    if (ev && eo[ch]) begin
      ist = ist | {1'b0, done[ch], rdy, 1'b1};
      ovr[ch] = ovr[ch] | done[ch];
      gov = gov | rdy;
      {done[ch], rdy, cdat[ch], lch, ldat} = {2'b11, v, ch, v};
    end
    // no answer time is assumed; only the watchdog ends a stall
    while (wreq !== 1'b0) begin
      @(posedge clk);
    end
    if (!w) chk("readdata", e & m, rdat & m);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // wait for the next conversion start and check its channel
  task conv(input logic [2:0] c);
    int n;
    n = 0;
    while (cs !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("start", {1'b1, c}, {cs, cch});
    ch = c;
  endtask

  // watchdog against a stalled answer
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end

  initial begin
    seed = 1;
    {errors, total_checks} = 0;
    {rst_n, rd, wr, eoc, adr, wdat, edat, ch} = 0;
    be = 4'hf;
    {en, done, ovr, rdy, gov, slp, lch, ldat, ist, imsk} = 0;
    foreach (cdat[i]) cdat[i] = 10'h000;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i]) acc(0, ra[i], 0, 0);
    acc(1, ADRS_OFF_IRQ_MASK, 32'h7, 0);
    acc(1, ADRS_OFF_CHEN, 32'h2d, 0);
    acc(1, ADRS_OFF_CTRL, 32'h1, 0);
    conv(0);
    acc(0, ADRS_OFF_STAT, 0, 1);
    conv(2);
    acc(0, 8'h44, 0, 1);
    conv(3);
    acc(1, ADRS_OFF_CHEN, 32'h2c, 1);
    conv(5);
    acc(1, ADRS_OFF_CHEN, 32'h0c, 0);
    acc(0, 8'h3c, 0, 1);
    acc(0, ADRS_OFF_STAT, 0, 0);
    acc(1, ADRS_OFF_CTRL, 32'h1, 0);
    conv(2);
    acc(0, ADRS_OFF_LAST, 0, 1);
    conv(3);
    acc(0, ADRS_OFF_STAT, 0, 1);
    acc(0, ADRS_OFF_STAT, 0, 0);
    acc(0, ADRS_OFF_LAST, 0, 0);
    acc(0, ADRS_OFF_STAT, 0, 0);
    for (int i = 0; i < 8; i++) acc(0, 8'(8'h30 + 4 * i), 0, 0);
    acc(0, ADRS_OFF_STAT, 0, 0);
    for (int i = 0; i < 20; i++) acc(0, 8'($random(seed)) & 8'h7c, 0, 0);
    // interrupt raised, masked, unmasked, then cleared by write-one
    for (int i = 0; i < 4; i++) begin
      if (i == 1) acc(1, ADRS_OFF_IRQ_MASK, 32'h0, 0);
      if (i == 2) acc(1, ADRS_OFF_IRQ_MASK, 32'h7, 0);
      if (i == 3) acc(1, ADRS_OFF_IRQ_STAT, 32'hf, 0);
      repeat (2) @(posedge clk);
      chk("irq", {31'h0, |(ist & imsk)}, {31'h0, irq});
    end
    acc(0, ADRS_OFF_IRQ_STAT, 0, 0);
    acc(1, ADRS_OFF_MODE, 32'h1, 0);
    repeat (4) @(posedge clk);
    chk("sleep idle", 32'h0, {31'h0, sl});
    acc(1, ADRS_OFF_CTRL, 32'h1, 0);
    conv(2);
    acc(0, ADRS_OFF_STAT, 0, 1);
    chk("sleep", 32'h1, {31'h0, sl});
    // ready set, then a last-result read meets a disabled channel's end
    conv(3);
    acc(1, ADRS_OFF_CHEN, 32'h04, 0);
    acc(0, ADRS_OFF_LAST, 0, 1);
    acc(0, ADRS_OFF_STAT, 0, 0);
    results();
  end
endmodule
